// [design/sled_top.sv]
/*
  Status LED indicator: maps module, axis and link status held in
  software-written registers onto eight bicolour LED drives.
  Assumes an AXI4-Lite master with at most one write and one read open.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
module sled_top #(
    parameter int unsigned FAST_CYC = sled_pkg::FAST_CYC
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // led drives
    output sled_pkg::sled_leds_t leds
);

    // aligned word address
    function automatic logic [11:0] word_of(input logic [11:0] a);
        word_of = {a[11:2], 2'h0};
    endfunction

    // register decode, shared by reads and writes
    function automatic logic mapped(input logic [11:0] a);
        logic [11:0] w;
        w = word_of(a);
        mapped = (w == sled_pkg::ADDR_AXIS) || (w == sled_pkg::ADDR_MODULE)
            || (w == sled_pkg::ADDR_LINK) || (w == sled_pkg::ADDR_LEDS);
    endfunction

    // byte-lane merge under write strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = r & m;
    endfunction

    // show a colour only in the on half of a phase
    function automatic logic [1:0] blink(input logic [1:0] col, input logic ph);
        blink = ph ? col : sled_pkg::COL_OFF;
    endfunction

    // status registers
    logic [31:0] axis_reg;
    logic [31:0] module_reg;
    logic [31:0] link_reg;

    // write channel state
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // timebase
    sled_pkg::sled_tb_t tb;

    sled_timebase #(
        .FAST_CYC(FAST_CYC)
    ) u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tb(tb)
    );

    // bus handshakes
    assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ce & ~s_axi_rvalid;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;

    // write target decode
    wire [11:0] wr_word = word_of(aw_addr);
    wire wr_ok = mapped(aw_addr);
    wire wr_axis = wr_go & (wr_word == sled_pkg::ADDR_AXIS);
    wire wr_mod = wr_go & (wr_word == sled_pkg::ADDR_MODULE);
    wire wr_link = wr_go & (wr_word == sled_pkg::ADDR_LINK);

    // read selection
    wire [11:0] rd_word = word_of(s_axi_araddr);
    wire rd_ok = mapped(s_axi_araddr);
    wire [31:0] leds_word = {16'h0000, leds.red, leds.green};
    wire [31:0] rd_val =
        (rd_word == sled_pkg::ADDR_AXIS) ? axis_reg :
        (rd_word == sled_pkg::ADDR_MODULE) ? module_reg :
        (rd_word == sled_pkg::ADDR_LINK) ? link_reg :
        (rd_word == sled_pkg::ADDR_LEDS) ? leds_word : 32'h0000_0000;

    // address and data held until both have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response; the led word is read-only and ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sled_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? sled_pkg::RESP_OKAY : sled_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // status registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            axis_reg <= sled_pkg::RESET_VAL;
            module_reg <= sled_pkg::RESET_VAL;
            link_reg <= sled_pkg::RESET_VAL;
        end else if (ce) begin
            if (wr_axis) begin
                axis_reg <= merge(axis_reg, w_data, w_strb, sled_pkg::AXIS_MASK);
            end
            if (wr_mod) begin
                module_reg <= merge(module_reg, w_data, w_strb, sled_pkg::MODULE_MASK);
            end
            if (wr_link) begin
                link_reg <= merge(link_reg, w_data, w_strb, sled_pkg::LINK_MASK);
            end
        end
    end

    // read data out of a register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sled_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? sled_pkg::RESP_OKAY : sled_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // axis, module and link status fields
    wire [3:0] ax_en = axis_reg[sled_pkg::AX_EN_LSB +: sled_pkg::N_AXIS];
    wire [3:0] ax_ns = axis_reg[sled_pkg::AX_NS_LSB +: sled_pkg::N_AXIS];
    wire [3:0] ax_fs = axis_reg[sled_pkg::AX_FS_LSB +: sled_pkg::N_AXIS];
    wire warn = module_reg[sled_pkg::MOD_WARN];
    wire stop_any = module_reg[sled_pkg::MOD_STOP] | (|ax_ns) | (|ax_fs);
    wire fatal = module_reg[sled_pkg::MOD_FATAL];
    wire [3:0] fatal_code = module_reg[sled_pkg::MOD_CODE_LSB +: 4];
    wire fw_load = module_reg[sled_pkg::MOD_FWLOAD];
    wire hw_bad = module_reg[sled_pkg::MOD_HWFAULT] | module_reg[sled_pkg::MOD_WDOG];
    wire boot = module_reg[sled_pkg::MOD_BOOT];
    wire [1:0] cfg_state = module_reg[sled_pkg::MOD_CFG_LSB +: 2];
    wire [1:0] servo = link_reg[sled_pkg::LNK_SERVO_LSB +: 2];
    wire [2:0] rio = link_reg[sled_pkg::LNK_RIO_LSB +: 3];

    // fatal blink-code sequencer
    typedef enum logic [1:0] {
        SLED_IDLE,
        SLED_ON,
        SLED_OFF,
        SLED_GAP
    } sled_code_t;

    sled_code_t code_st;
    sled_code_t next_code_st;
    logic [3:0] code_cnt;
    logic [3:0] next_code_cnt;
    wire [3:0] code_len = (fatal_code == 4'h0) ? sled_pkg::CODE_MIN : fatal_code;

    // count blinks on fast ticks, then a dark gap, then repeat
    always_comb begin
        next_code_st = code_st;
        next_code_cnt = code_cnt;
        case (code_st)
            SLED_IDLE: begin
                next_code_st = SLED_ON;
                next_code_cnt = code_len;
            end
            SLED_ON: begin
                if (tb.tick) begin
                    next_code_st = SLED_OFF;
                end
            end
            SLED_OFF: begin
                if (tb.tick) begin
                    if (code_cnt <= sled_pkg::CODE_MIN) begin
                        next_code_st = SLED_GAP;
                        next_code_cnt = sled_pkg::CODE_GAP_TICKS;
                    end else begin
                        next_code_st = SLED_ON;
                        next_code_cnt = code_cnt - 1'b1;
                    end
                end
            end
            SLED_GAP: begin
                if (tb.tick) begin
                    if (code_cnt <= sled_pkg::CODE_MIN) begin
                        next_code_st = SLED_ON;
                        next_code_cnt = code_len;
                    end else begin
                        next_code_cnt = code_cnt - 1'b1;
                    end
                end
            end
            default: begin
                next_code_st = SLED_IDLE;
            end
        endcase
        if (!fatal) begin
            next_code_st = SLED_IDLE;
        end
    end

    // sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_st <= SLED_IDLE;
            code_cnt <= 4'h0;
        end else if (ce) begin
            code_st <= next_code_st;
            code_cnt <= next_code_cnt;
        end
    end

    wire code_on = (code_st == SLED_ON);

    // per-led colour, {red, green}
    logic [1:0] col [sled_pkg::N_LED];

    // axis leds: fatal darkens, firmware load blinks in unison
    for (genvar i = 0; i < sled_pkg::N_AXIS; i++) begin : g_axis
        wire [1:0] normal =
            ax_fs[i] ? blink(sled_pkg::COL_RED, tb.fast) :
            ax_ns[i] ? sled_pkg::COL_RED :
            ax_en[i] ? sled_pkg::COL_GREEN :
            sled_pkg::COL_OFF;
        assign col[i] =
            fatal ? sled_pkg::COL_OFF :
            fw_load ? blink(sled_pkg::COL_GREEN, tb.fast) :
            normal;
    end

    // health led, most severe first
    assign col[sled_pkg::LED_HEALTH] =
        hw_bad ? sled_pkg::COL_AMBER :
        fatal ? blink(sled_pkg::COL_GREEN, code_on) :
        fw_load ? blink(sled_pkg::COL_GREEN, tb.fast) :
        stop_any ? blink(sled_pkg::COL_GREEN, tb.fast) :
        warn ? blink(sled_pkg::COL_GREEN, tb.slow) :
        sled_pkg::COL_GREEN;

    // configuration led
    wire [1:0] cfg_normal =
        boot ? sled_pkg::COL_AMBER :
        (cfg_state == sled_pkg::CFG_INVALID) ?
            blink(sled_pkg::COL_AMBER, tb.slow) :
        (cfg_state == sled_pkg::CFG_VALID) ? sled_pkg::COL_GREEN :
        blink(sled_pkg::COL_GREEN, tb.slow);
    assign col[sled_pkg::LED_CFG] =
        fatal ? sled_pkg::COL_OFF :
        fw_load ? blink(sled_pkg::COL_GREEN, tb.fast) :
        cfg_normal;

    // servo link led
    assign col[sled_pkg::LED_SERVO] =
        (servo == sled_pkg::SRV_FAILED) ? sled_pkg::COL_RED :
        (servo == sled_pkg::SRV_SETUP) ?
            blink(sled_pkg::COL_GREEN, tb.slow) :
        (servo == sled_pkg::SRV_ACTIVE) ? sled_pkg::COL_GREEN :
        sled_pkg::COL_OFF;

    // remote i/o link led
    assign col[sled_pkg::LED_RIO] =
        (rio == sled_pkg::RIO_FAILED) ? sled_pkg::COL_RED :
        (rio == sled_pkg::RIO_ID_BAD) ?
            (tb.slow ? sled_pkg::COL_GREEN : sled_pkg::COL_RED) :
        (rio == sled_pkg::RIO_CONFIG) ?
            blink(sled_pkg::COL_GREEN, tb.slow) :
        (rio == sled_pkg::RIO_ACTIVE) ? sled_pkg::COL_GREEN :
        sled_pkg::COL_OFF;

    // gather colours into drive vectors
    logic [7:0] next_green;
    logic [7:0] next_red;
    for (genvar k = 0; k < sled_pkg::N_LED; k++) begin : g_led
        assign next_green[k] = col[k][0];
        assign next_red[k] = col[k][1];
    end

    // registered led drives, all eight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leds <= '0;
        end else if (ce) begin
            leds.green <= next_green;
            leds.red <= next_red;
        end
    end

endmodule // sled_top

// [design/sled_pkg.sv]
/*
  Constants, field layouts and carrier types for the status LED indicator.
  Assumes a 100 MHz module clock and software access over AXI4-Lite.
*/
package sled_pkg;
    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FAST_MS = 500;
    localparam int unsigned SLOW_MS = 1000;
    localparam int unsigned FAST_CYC = (CLK_HZ / 1000) * FAST_MS;
    localparam int unsigned SLOW_PER_FAST = SLOW_MS / FAST_MS;
    localparam logic [3:0] CODE_GAP_TICKS = 4'h4;
    localparam logic [3:0] CODE_MIN = 4'h1;

    // bus
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] ADDR_AXIS = 12'h000;
    localparam logic [11:0] ADDR_MODULE = 12'h004;
    localparam logic [11:0] ADDR_LINK = 12'h008;
    localparam logic [11:0] ADDR_LEDS = 12'h00c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    // axis register fields
    localparam int unsigned N_AXIS = 4;
    localparam int unsigned AX_EN_LSB = 0;
    localparam int unsigned AX_NS_LSB = 4;
    localparam int unsigned AX_FS_LSB = 8;
    localparam logic [31:0] AXIS_MASK = 32'h0000_0fff;

    // module register fields
    localparam int unsigned MOD_WARN = 0;
    localparam int unsigned MOD_STOP = 1;
    localparam int unsigned MOD_FATAL = 2;
    localparam int unsigned MOD_CODE_LSB = 4;
    localparam int unsigned MOD_FWLOAD = 8;
    localparam int unsigned MOD_HWFAULT = 9;
    localparam int unsigned MOD_WDOG = 10;
    localparam int unsigned MOD_BOOT = 12;
    localparam int unsigned MOD_CFG_LSB = 13;
    localparam logic [31:0] MODULE_MASK = 32'h0000_77f7;

    // link register fields
    localparam int unsigned LNK_SERVO_LSB = 0;
    localparam int unsigned LNK_RIO_LSB = 2;
    localparam logic [31:0] LINK_MASK = 32'h0000_001f;

    // field codes
    localparam logic [1:0] CFG_NONE = 2'h0;
    localparam logic [1:0] CFG_VALID = 2'h1;
    localparam logic [1:0] CFG_INVALID = 2'h2;
    localparam logic [1:0] SRV_INACTIVE = 2'h0;
    localparam logic [1:0] SRV_ACTIVE = 2'h1;
    localparam logic [1:0] SRV_SETUP = 2'h2;
    localparam logic [1:0] SRV_FAILED = 2'h3;
    localparam logic [2:0] RIO_INACTIVE = 3'h0;
    localparam logic [2:0] RIO_ACTIVE = 3'h1;
    localparam logic [2:0] RIO_CONFIG = 3'h2;
    localparam logic [2:0] RIO_FAILED = 3'h3;
    localparam logic [2:0] RIO_ID_BAD = 3'h4;

    // led colours {red, green} and positions
    localparam logic [1:0] COL_OFF = 2'h0;
    localparam logic [1:0] COL_GREEN = 2'h1;
    localparam logic [1:0] COL_RED = 2'h2;
    localparam logic [1:0] COL_AMBER = 2'h3;
    localparam int unsigned N_LED = 8;
    localparam int unsigned LED_HEALTH = 4;
    localparam int unsigned LED_CFG = 5;
    localparam int unsigned LED_SERVO = 6;
    localparam int unsigned LED_RIO = 7;
    localparam int unsigned LEDS_RED_LSB = 8;

    // bicolour led drives
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
    } sled_leds_t;

    // shared blink timebase
    typedef struct packed {
        logic tick;
        logic fast;
        logic slow;
    } sled_tb_t;
endpackage

// [design/sled_timebase.sv]
/*
  Shared blink timebase: one cycle counter giving fast and slow phases.
  Assumes a single clock; clock enable low freezes the count.
*/
`timescale 1ns/1ns
module sled_timebase #(
    parameter int unsigned FAST_CYC = sled_pkg::FAST_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // phases
    output sled_pkg::sled_tb_t tb
);
    localparam int unsigned CW = $clog2(FAST_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(FAST_CYC - 1);
    localparam int unsigned SW = $clog2(sled_pkg::SLOW_PER_FAST + 1);
    localparam logic [SW-1:0] SLAST = SW'(sled_pkg::SLOW_PER_FAST - 1);

    logic [CW-1:0] cnt;
    logic [SW-1:0] scnt;
    wire wrap = (cnt == LAST);
    wire swrap = (scnt == SLAST);

    // one counter paces every indicator, so equal rates stay in phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            scnt <= '0;
            tb <= '0;
        end else if (ce) begin
            cnt <= wrap ? '0 : cnt + 1'b1;
            tb.tick <= wrap;
            if (wrap) begin
                tb.fast <= ~tb.fast;
                scnt <= swrap ? '0 : scnt + 1'b1;
                if (swrap) begin
                    tb.slow <= ~tb.slow;
                end
            end
        end
    end
endmodule // sled_timebase

// [sim/sled_monitor.sv]
/*
  Checker for the status LED indicator ports: bus handshakes and colours.
  Assumes one clock, synchronous active-low reset, bound to sled_top.
*/
`timescale 1ns/1ns
module sled_monitor (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // led drives
    input wire sled_pkg::sled_leds_t leds
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // request takes
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // bus answers, holds and refusals
    a_write_answer: assert property (s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write response not seen two cycles after take");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not seen one cycle after take");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before rready");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_ce_idle: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready high with clock enable low");
    a_bad_addr: assert property (s_rd_take and s_axi_araddr[11:2] > 10'h003 |=>
        s_axi_rresp == sled_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // colour sets the axis, health, config and servo leds may show
    a_axis_colour: assert property ((leds.red[3:0] & leds.green[3:0]) == 4'h0)
        else $error("axis led shows amber");
    a_status_colour: assert property ((leds.red[5:4] & ~leds.green[5:4]) == 2'h0)
        else $error("health or config led shows pure red");
    a_servo_colour: assert property (!(leds.red[6] && leds.green[6]))
        else $error("servo link led shows amber");
endmodule // sled_monitor

// [sim/tb_sled_top.sv]
/*
  Self-checking bench for the status LED indicator: register traffic
  over AXI4-Lite, then led patterns classed over a blink window.
  Assumes sled_top with a short FAST_CYC and sled_monitor bound to it.
*/
`timescale 1ns/1ns
module tb_sled_top;
    localparam int unsigned FAST = 8;
    localparam int unsigned WIN = 8 * FAST;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    sled_pkg::sled_leds_t leds;
    int n_errors, n_tests, seed, i;
    logic [47:0] corner [10];

    // design under test
    sled_top #(.FAST_CYC(FAST)) uut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .leds(leds)
    );

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // counts, verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic give_up();
        n_errors++;
        $display("BAD handshake expected answer seen none");
        complete_run();
    endtask

    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // one write, response ready raised after a random delay
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        int k;
        int dly;
        dly = $unsigned($random(seed)) % 4;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (bready && bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (k >= dly) bready <= 1'b1;
        end
        if (k == 50) give_up();
    endtask

    // one read, data ready raised after a random delay
    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        int k;
        int dly;
        dly = $unsigned($random(seed)) % 4;
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (rready && rvalid) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready) arvalid <= 1'b0;
            if (k >= dly) rready <= 1'b1;
        end
        if (k == 50) give_up();
    endtask

    // class per colour: 0 off, 1 on, 2 slow, 3 fast; nibble per led {red, green}
    task automatic measure(output logic [31:0] cls, output logic uni);
        logic [15:0] prev;
        int tg [16];
        int j, k;
        uni = 1'b1;
        repeat (2) @(posedge aclk);
        prev = leds;
        for (j = 0; j < 16; j++) tg[j] = 0;
        for (k = 0; k < WIN; k++) begin
            @(posedge aclk);
            for (j = 0; j < 16; j++) tg[j] += (leds[j] !== prev[j]);
            if (leds.green[5:0] != 6'h00 && leds.green[5:0] != 6'h3f) uni = 1'b0;
            prev = leds;
        end
        for (j = 0; j < 16; j++) begin
            cls[(j % 8) * 4 + (j / 8) * 2 +: 2] = tg[j] == 0 ? {1'b0, prev[j]} : tg[j] >= 6 ? 2'h3 : 2'h2;
        end
    endtask

    // expected classes from the register contents
    function automatic logic [31:0] exp_cls(input logic [31:0] ax, md, lk);
        logic [31:0] e;
        logic [1:0] cfg;
        int j;
        cfg = md[14:13];
        for (j = 0; j < 4; j++) begin
            e[j*4 +: 4] = md[2] ? 4'h0 : md[8] ? 4'h3 : ax[8+j] ? 4'hc :
                ax[4+j] ? 4'h4 : ax[j] ? 4'h1 : 4'h0;
        end
        e[19:16] = (md[9] | md[10]) ? 4'h5 : md[2] ? 4'h2 :
            (md[8] | md[1] | (|ax[11:4])) ? 4'h3 : md[0] ? 4'h2 : 4'h1;
        e[23:20] = md[2] ? 4'h0 : md[8] ? 4'h3 : md[12] ? 4'h5 :
            cfg == 2'h2 ? 4'ha : cfg == 2'h1 ? 4'h1 : 4'h2;
        e[27:24] = 4'(16'h4210 >> (lk[1:0] * 4));
        e[31:28] = 4'(32'h000a_4210 >> (lk[4:2] * 4));
        return e;
    endfunction

    // write three registers, read them back, class the leds
    task automatic run_case(input logic [31:0] ax, md, lk);
        logic [31:0] v [3];
        logic [11:0] ad [3];
        logic [31:0] mk [3];
        logic [31:0] cls;
        logic uni;
        int j;
        v = '{ax, md, lk};
        ad = '{sled_pkg::ADDR_AXIS, sled_pkg::ADDR_MODULE, sled_pkg::ADDR_LINK};
        mk = '{sled_pkg::AXIS_MASK, sled_pkg::MODULE_MASK, sled_pkg::LINK_MASK};
        for (j = 0; j < 3; j++) begin
            axi_write(ad[j], v[j], r);
            check_val("write resp", 32'(sled_pkg::RESP_OKAY), {30'h0, r});
            axi_read(ad[j], d, r);
            check_val("read back", v[j] & mk[j], d);
        end
        measure(cls, uni);
        check_val("led pattern", exp_cls(ax, md, lk), cls);
        if (md[8] && !md[2] && !md[9] && !md[10]) check_val("unison", 32'h1, {31'h0, uni});
        $display("case ax %h md %h lk %h done", ax, md, lk);
    endtask

    // main sequence
    initial begin
        seed = 79;
        n_errors = 0;
        n_tests = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        ce = 1'b1;
        wstrb = 4'hf;
        {awaddr, araddr, wdata} = 56'h0;
        corner = '{48'h0000_0000_0000, 48'h000f_2000_0005, 48'h00f0_0001_000a,
            48'h0f0f_4000_000f, 48'h0000_1001_0010, 48'h0fff_2014_0001, 48'h00ff_0100_0006,
            48'h0000_0204_0014, 48'h0000_0400_0002, 48'h0421_0000_0000};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 3; i++) begin
            axi_read(12'(i * 4), d, r);
            check_val("reset value", sled_pkg::RESET_VAL, d);
        end
        axi_write(12'h010, 32'hffff_ffff, r);
        check_val("unmapped write", 32'(sled_pkg::RESP_SLVERR), {30'h0, r});
        axi_read(12'h010, d, r);
        check_val("unmapped read", 32'(sled_pkg::RESP_SLVERR), {30'h0, r});
        axi_write(sled_pkg::ADDR_LEDS, 32'h0, r);
        check_val("led word write", 32'(sled_pkg::RESP_OKAY), {30'h0, r});
        wstrb <= 4'h2;
        axi_write(sled_pkg::ADDR_MODULE, 32'hffff_ffff, r);
        wstrb <= 4'hf;
        axi_read(sled_pkg::ADDR_MODULE, d, r);
        check_val("strobed write", 32'h0000_7700, d);
        ce <= 1'b0;
        @(posedge aclk);
        d = 32'(leds);
        @(posedge aclk);
        check_val("ready with ce low", 32'h0, {29'h0, awready, wready, arready});
        check_val("leds frozen", d, 32'(leds));
        ce <= 1'b1;
        @(posedge aclk);
        $display("bus and enable tests done");
        for (i = 0; i < 10; i++) begin
            run_case(32'(corner[i][47:32]), 32'(corner[i][31:16]), 32'(corner[i][15:0]));
            if (i == 1) begin
                axi_read(sled_pkg::ADDR_LEDS, d, r);
                check_val("led word", 32'h0000_00ff, d);
            end
        end
        for (i = 0; i < 12; i++) begin
            run_case($random(seed), $random(seed) & $random(seed) & ~32'he0, $random(seed));
        end
        complete_run();
    end
endmodule // tb_sled_top

bind sled_top sled_monitor u_mon (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .leds
);
